//--- common/mrps_pkg.sv
// package for the master reset and pin strap block
package mrps_pkg;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic        IFACE_SERIAL = 1'b0;
  localparam logic        IFACE_2WIRE  = 1'b1;
  localparam logic [1:0]  RATIO_DEFAULT = 2'h0;
  localparam logic [1:0]  GAIN_DEFAULT  = 2'h0;

  typedef struct packed {
    logic [1:0] ratio_sel;
    logic [1:0] gain_sel;
    logic       boost;
  } mrps_straps_t;

  typedef struct packed {
    logic master_reset_or_ratio_sel_lo;
    logic conv_ready_or_gain_sel_hi;
    logic osc_out_or_iface_select;
    logic osc_in_or_gain_sel_lo;
    logic chip_select_or_boost;
    logic serial_in_or_ratio_sel_hi;
  } mrps_pins_t;

  typedef enum logic [2:0] {
    MRPS_ST_HOLD   = 3'h1,
    MRPS_ST_SAMPLE = 3'h2,
    MRPS_ST_RUN    = 3'h4
  } mrps_state_t;
endpackage

//--- logic/mrps_core.sv
// master reset, mode sampling and pin strap latching
// Function
// - serial mode: low reset holds whole chip
// - pin reset forces all registers to defaults except bias, the ready output copy (follows i_conv_ready_n) and the reset and mode synchronizers
// - serial traffic ignored while reset low
// - internal clock gate off during reset
// - reset state equals power-on state
// - bias kept on when clock runs
// - reset pin latched as low ratio select
// - ready pin becomes high gain select input
// - oscillator pin selects interface mode
// - chip select boost, serial in ratio high
// - modulator bitstream output in serial mode only, ready output off meanwhile
// - mode sampled after every reset kind
`timescale 1ns/1ps
module mrps_core
  import mrps_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  input  wire mrps_pkg::mrps_pins_t i_pins,
  input  wire logic                i_watchdog_reset,
  input  wire logic                i_conv_ready_n,
  input  wire logic                i_modulator_bit,
  input  wire logic                i_modulator_en,
  output logic                     o_chip_reset_n,
  output logic                     o_clock_gate_en,
  output logic                     o_bias_en,
  output logic                     o_serial_enable,
  output logic                     o_iface_2wire,
  output mrps_pkg::mrps_straps_t   o_straps,
  output logic                     o_conv_ready_out,
  output logic                     o_conv_ready_oe,
  output logic                     o_modulator_bitstream_out,
  output logic                     o_modulator_oe
);
  import mrps_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] rst_sync;
    logic [SYNC_STAGES-1:0] mode_sync;
    logic [SYNC_STAGES-1:0] ovr_sync;
    logic [SYNC_STAGES-1:0] gsh_sync;
    logic [SYNC_STAGES-1:0] gsl_sync;
    logic [SYNC_STAGES-1:0] bst_sync;
    logic [SYNC_STAGES-1:0] rsh_sync;
    mrps_state_t            state;
    logic                   iface;
    mrps_straps_t           straps;
    logic                   chip_rst_n;
    logic                   clk_gate;
    logic                   serial_en;
    logic                   dr_out;
    logic                   dr_oe;
    logic                   mod_out;
    logic                   mod_oe;
    logic                   bias;
  } mrps_core_t;

  mrps_core_t st;
  mrps_core_t next_st;

  function automatic logic agreed(input logic [SYNC_STAGES-1:0] s);
    agreed = s[SYNC_STAGES-1];
  endfunction

  function automatic logic [SYNC_STAGES-1:0] shift_in(
    input logic [SYNC_STAGES-1:0] s, input logic d);
    shift_in = {s[SYNC_STAGES-2:0], d};
  endfunction

  logic pin_reset_n;
  logic strap_now;

  ////////////////////////////////////////////////////////////////////////////
  // next state; the watchdog relatch wins over the reset pin
  always_comb begin
    next_st = st;
    next_st.rst_sync  = shift_in(st.rst_sync, i_pins.master_reset_or_ratio_sel_lo);
    next_st.mode_sync = shift_in(st.mode_sync, i_pins.osc_out_or_iface_select);
    next_st.ovr_sync  = shift_in(st.ovr_sync, i_pins.master_reset_or_ratio_sel_lo);
    next_st.gsh_sync  = shift_in(st.gsh_sync, i_pins.conv_ready_or_gain_sel_hi);
    next_st.gsl_sync  = shift_in(st.gsl_sync, i_pins.osc_in_or_gain_sel_lo);
    next_st.bst_sync  = shift_in(st.bst_sync, i_pins.chip_select_or_boost);
    next_st.rsh_sync  = shift_in(st.rsh_sync, i_pins.serial_in_or_ratio_sel_hi);
    // reset pin counts only in serial mode; in 2-wire mode it is a strap
    pin_reset_n = (st.iface == IFACE_2WIRE) ||
                  (st.rst_sync[SYNC_STAGES-1] | st.rst_sync[SYNC_STAGES-2]);
    if (st.rst_sync[SYNC_STAGES-1] != st.rst_sync[SYNC_STAGES-2]) begin
      pin_reset_n = (st.iface == IFACE_2WIRE) || st.chip_rst_n;
    end
    strap_now = 1'b0;
    case (st.state)
      MRPS_ST_HOLD: begin
        // stay held for as long as the pin is low, not just one pass
        if (pin_reset_n) begin
          next_st.state = MRPS_ST_SAMPLE;
        end
      end
      MRPS_ST_SAMPLE: begin
        next_st.iface = agreed(st.mode_sync);
        strap_now     = (agreed(st.mode_sync) == IFACE_2WIRE);
        next_st.state = MRPS_ST_RUN;
      end
      MRPS_ST_RUN: begin
        if (i_watchdog_reset) begin
          next_st.state = MRPS_ST_SAMPLE;
          strap_now     = (st.iface == IFACE_2WIRE);
        end else if (!pin_reset_n) begin
          next_st = '0;
          next_st.rst_sync  = st.rst_sync;
          next_st.mode_sync = st.mode_sync;
          next_st.state     = MRPS_ST_HOLD;
        end
      end
      default: begin
        next_st.state = MRPS_ST_HOLD;
      end
    endcase
    if (strap_now) begin
      next_st.straps.ratio_sel = {agreed(st.rsh_sync), agreed(st.ovr_sync)};
      next_st.straps.gain_sel  = {agreed(st.gsh_sync), agreed(st.gsl_sync)};
      next_st.straps.boost     = agreed(st.bst_sync);
    end
    next_st.chip_rst_n = (next_st.state == MRPS_ST_RUN);
    next_st.clk_gate   = (next_st.state == MRPS_ST_RUN);
    next_st.serial_en  = (next_st.state == MRPS_ST_RUN) &&
                         (next_st.iface == IFACE_SERIAL);
    // ready pin is only driven in serial mode and when the bitstream is off
    next_st.dr_oe   = next_st.serial_en && !i_modulator_en;
    next_st.dr_out  = i_conv_ready_n;
    next_st.mod_oe  = next_st.serial_en && i_modulator_en;
    next_st.mod_out = next_st.mod_oe && i_modulator_bit;
    // bias drops only with power; a pin reset keeps it on while the clock runs
    next_st.bias    = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      // reset pin idles high; starting low would fake a pin reset after power-on
      st.rst_sync <= '1;
      st.state  <= MRPS_ST_HOLD;
      st.straps <= '{ratio_sel: RATIO_DEFAULT, gain_sel: GAIN_DEFAULT, boost: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_chip_reset_n           = st.chip_rst_n;
  assign o_clock_gate_en          = st.clk_gate;
  // analog bias stays on through a pin reset, only lost without power
  assign o_bias_en                = st.bias;
  assign o_serial_enable          = st.serial_en;
  assign o_iface_2wire            = st.iface;
  assign o_straps                 = st.straps;
  assign o_conv_ready_out         = st.dr_out;
  assign o_conv_ready_oe          = st.dr_oe;
  assign o_modulator_bitstream_out = st.mod_out;
  assign o_modulator_oe           = st.mod_oe;

  ////////////////////////////////////////////////////////////////////////////
  chk_serial_off_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_chip_reset_n |-> !o_serial_enable) else $error("serial active in reset");
  chk_gate_follows_rst: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_clock_gate_en == o_chip_reset_n) else $error("clock gate mismatch");
  chk_pin_low_resets: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_RUN && !pin_reset_n && !i_watchdog_reset) |=> !o_chip_reset_n)
    else $error("reset pin ignored");
  chk_release_sync: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_chip_reset_n) |-> $past(st.state) == MRPS_ST_SAMPLE)
    else $error("release not sequenced");
  chk_mode_sampled: assert property (@(posedge i_clk) disable iff (!i_nrst)
    st.state == MRPS_ST_SAMPLE |=> o_iface_2wire == $past(st.mode_sync[SYNC_STAGES-1]))
    else $error("mode not sampled");
  chk_straps_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    st.state == MRPS_ST_RUN && !i_watchdog_reset && pin_reset_n |=> $stable(o_straps))
    else $error("straps moved");
  chk_mod_only_serial: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_modulator_oe |-> !o_iface_2wire && !o_conv_ready_oe)
    else $error("bitstream in 2-wire");
  chk_defaults_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_RUN && !pin_reset_n && !i_watchdog_reset) |=>
    (o_straps == '0 && !o_iface_2wire)) else $error("defaults not restored");
  chk_hold_while_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_HOLD && !pin_reset_n) |=> (st.state == MRPS_ST_HOLD && !o_chip_reset_n))
    else $error("reset released while pin low");
  chk_bias_in_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_chip_reset_n) |-> o_bias_en)
    else $error("bias dropped by pin reset");
  chk_hold_equals_por: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_HOLD) |-> (o_straps == '0 && !o_iface_2wire && !o_serial_enable))
    else $error("hold state differs from power-on");
  chk_gate_is_run: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_clock_gate_en == (st.state == MRPS_ST_RUN))
    else $error("clock gate outside run");
  chk_ready_serial: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_conv_ready_oe |-> (o_serial_enable && !o_iface_2wire))
    else $error("ready pin driven in 2-wire");
  chk_serial_2w_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_iface_2wire |-> !o_serial_enable)
    else $error("serial port on in 2-wire");
  chk_pin_ignored_2w: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_RUN && o_iface_2wire && !i_watchdog_reset) |=> o_chip_reset_n)
    else $error("reset pin acted in 2-wire");
  chk_ratio_relatch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_RUN && i_watchdog_reset && o_iface_2wire) |=>
    (o_straps.ratio_sel[0] == $past(st.ovr_sync[SYNC_STAGES-1])))
    else $error("ratio strap not relatched");
  chk_gain_relatch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_RUN && i_watchdog_reset && o_iface_2wire) |=>
    (o_straps.gain_sel[1] == $past(st.gsh_sync[SYNC_STAGES-1])))
    else $error("gain strap not relatched");
  chk_boost_relatch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_RUN && i_watchdog_reset && o_iface_2wire) |=>
    (o_straps.boost == $past(st.bst_sync[SYNC_STAGES-1])))
    else $error("boost strap not relatched");
  chk_mod_follows: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_modulator_oe |-> (o_modulator_bitstream_out == $past(i_modulator_bit)))
    else $error("bitstream does not follow bit");
  chk_sample_once: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st.state == MRPS_ST_SAMPLE) |=> (st.state == MRPS_ST_RUN))
    else $error("sample state lingers");
endmodule // mrps_core

//--- verification/mrps_host.sv
// host model that drives the reset and strap pins
`timescale 1ns/1ps
module mrps_host
  import mrps_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire mrps_pkg::mrps_pins_t i_want,
  output mrps_pkg::mrps_pins_t      o_pins
);
  // pins move just after a rising edge, like a port register of a controller
  always_ff @(posedge i_clk) o_pins <= i_want;
  // clock always runs here, so early results after reset need not be dropped
endmodule // mrps_host

//--- verification/test_master_reset_and_pin_straps.sv
// self-checking bench for the master reset and pin strap block
`timescale 1ns/1ps
module test_master_reset_and_pin_straps;
  import mrps_pkg::*;
  logic         i_clk  = 1'b0;
  logic         i_nrst = 1'b0;
  logic         wd     = 1'b0;
  logic         mbit   = 1'b0;
  logic         men    = 1'b0;
  logic         cready = 1'b1;
  mrps_pins_t   want   = mrps_pins_t'(6'h20);
  mrps_pins_t   pins;
  mrps_straps_t straps;
  logic         rst_n, gate, bias, ser, two, rdy, rdy_oe, mout, moe;
  int           err_total = 0;
  int           n_checks  = 0;
  mrps_host host (.i_clk(i_clk), .i_want(want), .o_pins(pins));
  mrps_core uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_pins(pins), .i_watchdog_reset(wd),
    .i_conv_ready_n(cready), .i_modulator_bit(mbit), .i_modulator_en(men),
    .o_chip_reset_n(rst_n), .o_clock_gate_en(gate), .o_bias_en(bias),
    .o_serial_enable(ser), .o_iface_2wire(two), .o_straps(straps),
    .o_conv_ready_out(rdy), .o_conv_ready_oe(rdy_oe),
    .o_modulator_bitstream_out(mout), .o_modulator_oe(moe));
  initial forever #50 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait; sync flops make the exact edge a design choice
  task automatic wait_rst(input logic lvl);
    for (int n = 0; n < 10 && rst_n !== lvl; n++) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse_wd;
    repeat (6) @(posedge i_clk);
    wd <= 1'b1;
    @(posedge i_clk) wd <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power;
    wait_rst(1'b1);
    cmp(8'({rst_n, gate, ser, two, bias}), 8'h1d);
    $display("test power done");
  endtask
  task automatic t_pin_reset;
    @(posedge i_clk) want <= mrps_pins_t'(6'h0f);
    wait_rst(1'b0);
    cmp(8'({rst_n, gate, ser, bias}), 8'h01);
    cmp(8'(straps), 8'h00);
    @(posedge i_clk) want <= mrps_pins_t'(6'h2f);
    wait_rst(1'b1);
    repeat (2) @(posedge i_clk);
    #1;
    cmp(8'({ser, two, straps}), 8'h3b);
    $display("test pin reset done");
  endtask
  task automatic t_two_wire;
    @(posedge i_clk) want <= mrps_pins_t'(6'h0f);
    repeat (8) @(posedge i_clk);
    #1;
    cmp(8'({rst_n, straps}), 8'h3b);
    @(posedge i_clk) want <= mrps_pins_t'(6'h2b);
    pulse_wd();
    cmp(8'(straps), 8'h19);
    @(posedge i_clk) want <= mrps_pins_t'(6'h20);
    pulse_wd();
    cmp(8'({rst_n, ser, two}), 8'h06);
    $display("test two wire done");
  endtask
  task automatic t_modulator;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk) begin
        men <= 1'b1;
        mbit <= k[0];
      end
      @(posedge i_clk);
      #1;
      cmp(8'({moe, mout}), 8'({1'b1, k[0]}));
    end
    @(posedge i_clk) begin
      men    <= 1'b0;
      cready <= 1'b0;
    end
    @(posedge i_clk);
    #1;
    cmp(8'({rdy_oe, rdy, moe}), 8'h04);
    $display("test modulator done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_power();
    t_pin_reset();
    t_two_wire();
    t_modulator();
    test_done();
  end
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule // test_master_reset_and_pin_straps
